// file: src/csi2_tx_defs.svh
// Constants for the CSI-2 transmit packet and output control block
`ifndef CSI2_TX_DEFS_SVH
`define CSI2_TX_DEFS_SVH
// Register offsets
`define OFS_GENERAL_CONFIGURATION 8'h02
`define OFS_TX_RATE_SELECT 8'h1f
`define OFS_FORWARDING_CONTROL_ONE 8'h20
`define OFS_FORWARDING_CONTROL_TWO 8'h21
`define OFS_RX_PORT_SELECT 8'h4c
`define OFS_RAW10_CONTEXT_ID 8'h70
`define OFS_RAW12_CONTEXT_ID 8'h71
`define OFS_CHANNEL_REMAP 8'h72
// Reset values
`define RST_GENERAL_CONFIGURATION 8'h07
`define RST_TX_RATE_SELECT 8'h00
`define RST_FORWARDING_CONTROL_ONE 8'h02
`define RST_FORWARDING_CONTROL_TWO 8'h00
`define RST_RX_PORT_SELECT 8'h00
`define RST_RAW10_CONTEXT_ID 8'h2b
`define RST_RAW12_CONTEXT_ID 8'h2c
`define RST_CHANNEL_REMAP 8'he4
// Field positions
`define BIT_OUTPUT_ENABLE 0
`define BIT_OUTPUT_SLEEP_SELECT 1
`define BIT_INACTIVITY_MODE 2
`define BIT_REF_CLK_MODE 3
`define BIT_TIMING_OVERRIDE 7
`define BIT_REPLICATE 0
`define BIT_PORT_SELECT 0
`define FWD_MAP_LSB 0
`define FWD_DISABLE_LSB 4
`define RATE_CODE_MSB 1
`define RATE_CODE_LSB 0
`define DI_VC_MSB 7
`define DI_VC_LSB 6
`define DI_DT_MSB 5
`define DI_DT_LSB 0
// Rate codes and multipliers of the reference clock
`define RATE_CODE_FULL 2'b00
`define RATE_CODE_RESERVED 2'b01
`define RATE_CODE_HALF 2'b10
`define RATE_CODE_QUARTER 2'b11
`define RATE_MULT_FULL 64
`define RATE_MULT_HALF 32
`define RATE_MULT_QUARTER 16
// Packet framing
`define SHORT_DT_MAX 6'h0f
`define HEADER_LAST 2'h3
`define FOOTER_LAST 2'h1
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define ECC_MASK_P0 24'hf12cb7
`define ECC_MASK_P1 24'hf2555b
`define ECC_MASK_P2 24'h749a6d
`define ECC_MASK_P3 24'hb8e38e
`define ECC_MASK_P4 24'hdf03f0
`define ECC_MASK_P5 24'heffc00
`endif

// file: src/csi2_tx_pkg.sv
// Types for the CSI-2 transmit packet and output control block
package csi2_tx_pkg;
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_HEAD = 4'b0010,
        ST_PAY = 4'b0100,
        ST_FOOT = 4'b1000
    } tx_state_type;

    typedef enum logic [1:0]
    {
        PIN_HIZ = 2'b00,
        PIN_HS0 = 2'b01,
        PIN_LP11 = 2'b10,
        PIN_VALID = 2'b11
    } pin_state_type;
endpackage : csi2_tx_pkg

// file: src/csi2_tx_packet_output_control.sv
// CSI-2 transmit packet framer, channel mapping, rate select and output pin state control
// Function
// - Long packet is 32-bit header, byte payload, then 16-bit footer.
// - Header holds data identifier, 16-bit word count, then ECC byte.
// - Word count equals number of payload bytes sent.
// - Header ECC covers identifier and word count; corrects one, detects two.
// - Footer carries CRC-16 over the payload bytes.
// - Virtual channel sits in the two top bits of the identifier.
// - Data type sits in the six low bits of the identifier.
// - CSI-2 input packets keep their data type unchanged.
// - RAW input is wrapped with the port's configured channel and type.
// - Per-port RAW10 and RAW12 context registers give channel and type.
// - Packets from up to four channels interleave on one link.
// - In CSI-2 mode each port remaps every incoming channel by its register.
// - Rate code 00 full, 10 half, 11 quarter rate; 01 reserved.
// - Lane rate scales with the reference clock frequency.
// - Timing auto-loads at full and half rate with override bit 7 clear, else software overrides.
// - Replicate copies port 0 onto port 1 and enables second clock lane.
// - Power-down pin high and sleep select 0 force HS-0.
// - Pin low, or sleep select 1 with enable 0, gives high impedance.
// - Enabled, no active input: Hi-Z if mode 0, LP-11 if mode 1.
// - Enabled, active input: LP-11 if forwarding disabled, else valid.
// - A transmit port is active when any mapped receive port is locked.
// - Types 0x00 to 0x0F go out as short packets without payload.
`timescale 1ns/1ps
`include "csi2_tx_defs.svh"
module csi2_tx_packet_output_control
    import csi2_tx_pkg::*;
#(
    parameter int REF_CLK_KHZ = 25000
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_power_down_pin_n,
    input wire logic [1:0] i_rx_lock,
    input wire logic i_link_clk,
    input wire logic i_pkt_valid,
    output logic o_pkt_ready,
    input wire logic i_pkt_port,
    input wire logic i_pkt_raw,
    input wire logic i_pkt_raw12,
    input wire logic [1:0] i_pkt_vc,
    input wire logic [5:0] i_pkt_dt,
    input wire logic [15:0] i_pkt_wc,
    input wire logic i_pay_valid,
    input wire logic [7:0] i_pay_data,
    output logic o_pay_ready,
    output logic [7:0] o_tx0_byte,
    output logic o_tx0_valid,
    output logic [7:0] o_tx1_byte,
    output logic o_tx1_valid,
    output logic [1:0] o_tx0_pin_state,
    output logic [1:0] o_tx1_pin_state,
    output logic o_clk_lane1_en,
    output logic [11:0] o_lane_rate_mbps,
    output logic o_rate_reserved,
    output logic o_timing_auto,
    output logic o_ref_clk_mode
);
    if (REF_CLK_KHZ < 1000 || REF_CLK_KHZ > 60000)
    begin : g_bad_ref_clk
        $error("REF_CLK_KHZ out of range");
    end

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [7:0] ecc_calc(input logic [23:0] d);
        ecc_calc = {2'b00, ^(d & `ECC_MASK_P5), ^(d & `ECC_MASK_P4), ^(d & `ECC_MASK_P3),
                    ^(d & `ECC_MASK_P2), ^(d & `ECC_MASK_P1), ^(d & `ECC_MASK_P0)};
    endfunction : ecc_calc

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
            begin
                r = (r >> 1) ^ `CRC_POLY;
            end
            else
            begin
                r = r >> 1;
            end
        end
        crc_byte = r;
    endfunction : crc_byte

    function automatic pin_state_type pin_state_f(input logic power_down_pin, input logic sleep_sel,
                                                  input logic output_enable_bit, input logic mode,
                                                  input logic active, input logic fwd_ok);
        if (!power_down_pin)
        begin
            pin_state_f = PIN_HIZ;
        end
        else if (!sleep_sel)
        begin
            pin_state_f = PIN_HS0;
        end
        else if (!output_enable_bit)
        begin
            pin_state_f = PIN_HIZ;
        end
        else if (!active)
        begin
            pin_state_f = mode ? PIN_LP11 : PIN_HIZ;
        end
        else
        begin
            pin_state_f = fwd_ok ? PIN_VALID : PIN_LP11;
        end
    endfunction : pin_state_f

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] gen_cfg_reg;
    logic [7:0] rate_sel_reg;
    logic [7:0] fwd_one_reg;
    logic [7:0] fwd_two_reg;
    logic [7:0] port_sel_reg;
    logic [7:0] raw10_reg [0:1];
    logic [7:0] raw12_reg [0:1];
    logic [7:0] remap_reg [0:1];
    logic [7:0] rdata_reg;
    wire logic sel = port_sel_reg[`BIT_PORT_SELECT];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gen_cfg_reg <= `RST_GENERAL_CONFIGURATION;
            rate_sel_reg <= `RST_TX_RATE_SELECT;
            fwd_one_reg <= `RST_FORWARDING_CONTROL_ONE;
            fwd_two_reg <= `RST_FORWARDING_CONTROL_TWO;
            port_sel_reg <= `RST_RX_PORT_SELECT;
            for (int p = 0; p < 2; p++)
            begin
                raw10_reg[p] <= `RST_RAW10_CONTEXT_ID;
                raw12_reg[p] <= `RST_RAW12_CONTEXT_ID;
                remap_reg[p] <= `RST_CHANNEL_REMAP;
            end
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                `OFS_GENERAL_CONFIGURATION: gen_cfg_reg <= i_reg_wdata;
                `OFS_TX_RATE_SELECT: rate_sel_reg <= i_reg_wdata;
                `OFS_FORWARDING_CONTROL_ONE: fwd_one_reg <= i_reg_wdata;
                `OFS_FORWARDING_CONTROL_TWO: fwd_two_reg <= i_reg_wdata;
                `OFS_RX_PORT_SELECT: port_sel_reg <= i_reg_wdata;
                `OFS_RAW10_CONTEXT_ID: raw10_reg[sel] <= i_reg_wdata;
                `OFS_RAW12_CONTEXT_ID: raw12_reg[sel] <= i_reg_wdata;
                `OFS_CHANNEL_REMAP: remap_reg[sel] <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    wire logic [7:0] rd_mux =
        (i_reg_addr == `OFS_GENERAL_CONFIGURATION) ? gen_cfg_reg :
        (i_reg_addr == `OFS_TX_RATE_SELECT) ? rate_sel_reg :
        (i_reg_addr == `OFS_FORWARDING_CONTROL_ONE) ? fwd_one_reg :
        (i_reg_addr == `OFS_FORWARDING_CONTROL_TWO) ? fwd_two_reg :
        (i_reg_addr == `OFS_RX_PORT_SELECT) ? port_sel_reg :
        (i_reg_addr == `OFS_RAW10_CONTEXT_ID) ? raw10_reg[sel] :
        (i_reg_addr == `OFS_RAW12_CONTEXT_ID) ? raw12_reg[sel] :
        (i_reg_addr == `OFS_CHANNEL_REMAP) ? remap_reg[sel] : 8'h00;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_reg <= 8'h00;
        end
        else if (i_reg_rd)
        begin
            rdata_reg <= rd_mux;
        end
    end
    assign o_reg_rdata = rdata_reg;

    // ****************************************
    // Pin synchronisers and link clock edge
    // ****************************************
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic link_prev_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            link_prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= {i_link_clk, i_rx_lock, i_power_down_pin_n};
            sync_reg <= meta_reg;
            link_prev_reg <= sync_reg[3];
        end
    end
    wire logic pdb_sync = sync_reg[0];
    wire logic [1:0] lock_sync = sync_reg[2:1];
    wire logic link_edge = sync_reg[3] & ~link_prev_reg;

    // ****************************************
    // Rate select
    // ****************************************
    localparam int RATE_FULL = REF_CLK_KHZ * `RATE_MULT_FULL / 1000;
    localparam int RATE_HALF = REF_CLK_KHZ * `RATE_MULT_HALF / 1000;
    localparam int RATE_QUARTER = REF_CLK_KHZ * `RATE_MULT_QUARTER / 1000;
    wire logic [1:0] rate_code = rate_sel_reg[`RATE_CODE_MSB:`RATE_CODE_LSB];
    assign o_lane_rate_mbps =
        (rate_code == `RATE_CODE_FULL) ? 12'(RATE_FULL) :
        (rate_code == `RATE_CODE_HALF) ? 12'(RATE_HALF) :
        (rate_code == `RATE_CODE_QUARTER) ? 12'(RATE_QUARTER) : 12'h000;
    assign o_rate_reserved = (rate_code == `RATE_CODE_RESERVED);
    assign o_timing_auto = ((rate_code == `RATE_CODE_FULL) || (rate_code == `RATE_CODE_HALF))
                           && !rate_sel_reg[`BIT_TIMING_OVERRIDE];
    assign o_ref_clk_mode = gen_cfg_reg[`BIT_REF_CLK_MODE];

    // ****************************************
    // Output pin state
    // ****************************************
    wire logic replicate = fwd_two_reg[`BIT_REPLICATE];
    wire logic [1:0] map_tx1 = fwd_one_reg[`FWD_MAP_LSB +: 2];
    wire logic [1:0] fwd_dis = fwd_one_reg[`FWD_DISABLE_LSB +: 2];
    wire logic [1:0] map_tx0 = ~map_tx1;
    wire logic active0 = |(lock_sync & map_tx0);
    wire logic active1 = |(lock_sync & map_tx1);
    wire logic fwd_ok0 = |(lock_sync & map_tx0 & ~fwd_dis);
    wire logic fwd_ok1 = |(lock_sync & map_tx1 & ~fwd_dis);
    wire logic oss = gen_cfg_reg[`BIT_OUTPUT_SLEEP_SELECT];
    wire logic output_enable_bit = gen_cfg_reg[`BIT_OUTPUT_ENABLE];
    wire logic imode = gen_cfg_reg[`BIT_INACTIVITY_MODE];
    wire pin_state_type pin0_next =
        pin_state_f(pdb_sync, oss, output_enable_bit, imode, active0, fwd_ok0);
    wire pin_state_type pin1_own = pin_state_f(pdb_sync, oss, output_enable_bit, imode, active1, fwd_ok1);
    wire pin_state_type pin1_next = replicate ? pin0_next : pin1_own;
    pin_state_type pin0_reg;
    pin_state_type pin1_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin0_reg <= PIN_HIZ;
            pin1_reg <= PIN_HIZ;
        end
        else
        begin
            pin0_reg <= pin0_next;
            pin1_reg <= pin1_next;
        end
    end
    assign o_tx0_pin_state = pin0_reg;
    assign o_tx1_pin_state = pin1_reg;
    assign o_clk_lane1_en = replicate;

    a_hs0_forced: assert property (@(posedge i_clk) disable iff (i_rst)
        (pdb_sync && !oss) |=> (pin0_reg == PIN_HS0) && (pin1_reg == PIN_HS0))
        else $error("outputs not in HS-0");
    a_hiz_powerdown: assert property (@(posedge i_clk) disable iff (i_rst)
        (!pdb_sync || (oss && !output_enable_bit)) |=> (pin0_reg == PIN_HIZ))
        else $error("outputs not high impedance");

    // ****************************************
    // Packet framer
    // ****************************************
    tx_state_type state_reg;
    tx_state_type state_next;
    logic [31:0] hdr_reg;
    logic short_reg;
    logic [1:0] cnt_reg;
    logic [15:0] rem_reg;
    logic [15:0] crc_reg;
    logic [7:0] byte_reg;
    logic valid_reg;

    // Identifier build: RAW context or remapped incoming channel
    wire logic [7:0] raw_ctx = i_pkt_raw12 ? raw12_reg[i_pkt_port] : raw10_reg[i_pkt_port];
    wire logic [7:0] remap = remap_reg[i_pkt_port];
    wire logic [1:0] vc_mapped = remap[{i_pkt_vc, 1'b0} +: 2];
    wire logic [1:0] vc_out = i_pkt_raw ? raw_ctx[`DI_VC_MSB:`DI_VC_LSB] : vc_mapped;
    wire logic [5:0] dt_out = i_pkt_raw ? raw_ctx[`DI_DT_MSB:`DI_DT_LSB] : i_pkt_dt;
    wire logic [7:0] di_out = {vc_out, dt_out};
    wire logic [23:0] hdr_data = {i_pkt_wc, di_out};
    wire logic [31:0] hdr_full = {ecc_calc(hdr_data), hdr_data};
    wire logic accept = i_pkt_valid && (state_reg == ST_IDLE);
    wire logic pay_take = (state_reg == ST_PAY) && link_edge && i_pay_valid;
    wire logic head_done = (state_reg == ST_HEAD) && link_edge && (cnt_reg == `HEADER_LAST);
    wire logic foot_done = (state_reg == ST_FOOT) && link_edge && (cnt_reg == `FOOTER_LAST);
    wire logic wc_zero = (hdr_reg[23:8] == 16'h0000);
    wire logic [7:0] hdr_byte = hdr_reg[{cnt_reg, 3'b000} +: 8];
    wire logic [7:0] foot_byte = cnt_reg[0] ? crc_reg[15:8] : crc_reg[7:0];

    assign o_pkt_ready = (state_reg == ST_IDLE);
    assign o_pay_ready = (state_reg == ST_PAY) && link_edge;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept)
                begin
                    state_next = ST_HEAD;
                end
            end
            ST_HEAD:
            begin
                if (head_done)
                begin
                    state_next = short_reg ? ST_IDLE : (wc_zero ? ST_FOOT : ST_PAY);
                end
            end
            ST_PAY:
            begin
                if (pay_take && (rem_reg == 16'h0001))
                begin
                    state_next = ST_FOOT;
                end
            end
            ST_FOOT:
            begin
                if (foot_done)
                begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            hdr_reg <= 32'h00000000;
            short_reg <= 1'b0;
            cnt_reg <= 2'h0;
            rem_reg <= 16'h0000;
            crc_reg <= `CRC_INIT;
            byte_reg <= 8'h00;
            valid_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            valid_reg <= 1'b0;
            if (accept)
            begin
                hdr_reg <= hdr_full;
                short_reg <= (dt_out <= `SHORT_DT_MAX);
                rem_reg <= i_pkt_wc;
                cnt_reg <= 2'h0;
                crc_reg <= `CRC_INIT;
            end
            if ((state_reg == ST_HEAD) && link_edge)
            begin
                byte_reg <= hdr_byte;
                valid_reg <= 1'b1;
                cnt_reg <= cnt_reg + 2'h1;
            end
            if (pay_take)
            begin
                byte_reg <= i_pay_data;
                valid_reg <= 1'b1;
                rem_reg <= rem_reg - 16'h0001;
                crc_reg <= crc_byte(crc_reg, i_pay_data);
                cnt_reg <= 2'h0;
            end
            if ((state_reg == ST_FOOT) && link_edge)
            begin
                byte_reg <= foot_byte;
                valid_reg <= 1'b1;
                cnt_reg <= cnt_reg + 2'h1;
            end
            if (head_done)
            begin
                cnt_reg <= 2'h0;
            end
        end
    end

    assign o_tx0_byte = byte_reg;
    assign o_tx0_valid = valid_reg;
    assign o_tx1_byte = replicate ? byte_reg : 8'h00;
    assign o_tx1_valid = replicate & valid_reg;

    a_short_no_payload: assert property (@(posedge i_clk) disable iff (i_rst)
        head_done && short_reg |=> (state_reg == ST_IDLE))
        else $error("short packet did not end after header");
    a_long_to_payload: assert property (@(posedge i_clk) disable iff (i_rst)
        head_done && !short_reg && !wc_zero
        |=> (state_reg == ST_PAY) && (rem_reg == hdr_reg[23:8]))
        else $error("long packet did not enter payload");
    a_payload_count: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == ST_PAY) |-> (rem_reg != 16'h0000))
        else $error("payload ran past word count");
    a_header_ecc: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg != ST_IDLE) |-> (hdr_reg[31:24] == ecc_calc(hdr_reg[23:0])))
        else $error("header ECC mismatch");
    a_raw_context: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && i_pkt_raw && !i_pkt_raw12 |=> (hdr_reg[7:0] == $past(raw10_reg[i_pkt_port])))
        else $error("RAW10 context not applied");
    a_type_passthrough: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && !i_pkt_raw |=> (hdr_reg[5:0] == $past(i_pkt_dt)))
        else $error("data type changed");
    a_footer_crc: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == ST_FOOT) && link_edge && (cnt_reg == 2'h0)
        |=> valid_reg && (byte_reg == $past(crc_reg[7:0])))
        else $error("footer low byte is not the CRC");
    a_replicate_copy: assert property (@(posedge i_clk) disable iff (i_rst)
        replicate |-> (o_tx1_byte == o_tx0_byte) && (o_tx1_valid == o_tx0_valid))
        else $error("port 1 differs from port 0");
endmodule : csi2_tx_packet_output_control

// file: verification/csi2_rx_model.sv
// Downstream receiver model: link byte clock source and byte capture
`timescale 1ns/1ps
module csi2_rx_model
(
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_byte0,
    input wire logic i_valid0,
    input wire logic [7:0] i_byte1,
    input wire logic i_valid1,
    output logic o_link_clk
);
    // ****************************************
    // Link clock and capture queues
    // ****************************************
    logic [7:0] q0[$];
    logic [7:0] q1[$];

    initial
    begin
        o_link_clk = 1'b0;
        forever
        begin
            #200;
            o_link_clk = i_run ? ~o_link_clk : 1'b0;
        end
    end

    always @(posedge i_clk)
    begin
        if (i_valid0)
            q0.push_back(i_byte0);
        if (i_valid1)
            q1.push_back(i_byte1);
    end
endmodule : csi2_rx_model

// file: verification/csi2_tx_packet_output_control_test.sv
// Testbench for the CSI-2 transmit packet and output control block
`timescale 1ns/1ps
`include "csi2_tx_defs.svh"
module csi2_tx_packet_output_control_test
    import csi2_tx_pkg::*;
;
    // ****************************************
    // Signals, tables and instances
    // ****************************************
    logic i_clk, i_rst, i_reg_wr, i_reg_rd, i_power_down_pin_n, i_link_clk, run;
    logic i_pkt_valid, i_pkt_port, i_pkt_raw, i_pkt_raw12, i_pay_valid;
    logic [7:0] i_reg_addr, i_reg_wdata, i_pay_data, rdata, tx0, tx1;
    logic [1:0] i_rx_lock, i_pkt_vc, ps0, ps1;
    logic [5:0] i_pkt_dt;
    logic [15:0] i_pkt_wc;
    logic [11:0] mbps;
    logic pkt_ready, pay_ready, v0, v1, lane1, rsv, t_auto, rmode;
    logic [7:0] none[$];
    int err_count, n_compared;
    localparam logic [15:0] REGS [9] = '{{`OFS_GENERAL_CONFIGURATION, `RST_GENERAL_CONFIGURATION},
        {`OFS_TX_RATE_SELECT, `RST_TX_RATE_SELECT}, {`OFS_RX_PORT_SELECT, `RST_RX_PORT_SELECT},
        {`OFS_FORWARDING_CONTROL_ONE, `RST_FORWARDING_CONTROL_ONE}, {8'h55, 8'h00},
        {`OFS_FORWARDING_CONTROL_TWO, `RST_FORWARDING_CONTROL_TWO},
        {`OFS_RAW10_CONTEXT_ID, `RST_RAW10_CONTEXT_ID}, {`OFS_CHANNEL_REMAP, `RST_CHANNEL_REMAP},
        {`OFS_RAW12_CONTEXT_ID, `RST_RAW12_CONTEXT_ID}};
    // Pin, config, forwarding, lock, expected tx0 and tx1 pin states
    localparam logic [31:0] PINS [8] = '{32'h00702000, 32'h10702022, 32'h10302000, 32'h10502311,
        32'h10602300, 32'h10702223, 32'h10722222, 32'h10702333};
    localparam logic [11:0] MBPS [4] = '{12'h640, 12'h000, 12'h320, 12'h190};

    csi2_tx_packet_output_control uut
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
        .i_power_down_pin_n(i_power_down_pin_n), .i_rx_lock(i_rx_lock), .i_link_clk(i_link_clk),
        .i_pkt_valid(i_pkt_valid), .o_pkt_ready(pkt_ready), .i_pkt_port(i_pkt_port),
        .i_pkt_raw(i_pkt_raw), .i_pkt_raw12(i_pkt_raw12), .i_pkt_vc(i_pkt_vc),
        .i_pkt_dt(i_pkt_dt), .i_pkt_wc(i_pkt_wc), .i_pay_valid(i_pay_valid),
        .i_pay_data(i_pay_data), .o_pay_ready(pay_ready), .o_tx0_byte(tx0), .o_tx0_valid(v0),
        .o_tx1_byte(tx1), .o_tx1_valid(v1), .o_tx0_pin_state(ps0), .o_tx1_pin_state(ps1),
        .o_clk_lane1_en(lane1), .o_lane_rate_mbps(mbps), .o_rate_reserved(rsv),
        .o_timing_auto(t_auto), .o_ref_clk_mode(rmode)
    );

    csi2_rx_model rx
    (
        .i_clk(i_clk), .i_run(run), .i_byte0(tx0), .i_valid0(v0), .i_byte1(tx1),
        .i_valid1(v1), .o_link_clk(i_link_clk)
    );

    initial
    begin
        i_clk = 1'b0;
        forever
            #25 i_clk = ~i_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(posedge i_clk);
        #1 i_reg_wr = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(posedge i_clk);
        #1 i_reg_rd = 1'b0;
        d = rdata;
        @(posedge i_clk);
        #1;
    endtask : rd

    function automatic logic [7:0] ecc(input logic [23:0] d);
        ecc = {2'b00, ^(d & `ECC_MASK_P5), ^(d & `ECC_MASK_P4), ^(d & `ECC_MASK_P3),
            ^(d & `ECC_MASK_P2), ^(d & `ECC_MASK_P1), ^(d & `ECC_MASK_P0)};
    endfunction : ecc

    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = `CRC_INIT;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            repeat (8)
                c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
        end
        crc = c;
    endfunction : crc

    task automatic reg_test();
        logic [7:0] d;
        wr(8'h55, 8'hff);
        foreach (REGS[i])
        begin
            rd(REGS[i][15:8], d);
            check(d, REGS[i][7:0]);
        end
    endtask : reg_test

    task automatic pin_test();
        foreach (PINS[r])
        begin
            i_power_down_pin_n = PINS[r][28];
            i_rx_lock = PINS[r][9:8];
            wr(`OFS_GENERAL_CONFIGURATION, PINS[r][27:20]);
            wr(`OFS_FORWARDING_CONTROL_ONE, PINS[r][19:12]);
            repeat (4) @(posedge i_clk);
            #1 check(ps0, PINS[r][5:4]);
            check(ps1, PINS[r][1:0]);
        end
    endtask : pin_test

    task automatic rate_test();
        for (int c = 0; c < 4; c++)
        begin
            wr(`OFS_TX_RATE_SELECT, 8'(c));
            check(mbps, MBPS[c]);
            check(rsv, c == 1);
            check(t_auto, c == 0 || c == 2);
        end
        wr(`OFS_TX_RATE_SELECT, 8'h83);
        check(t_auto, 1'b0);
        check(rmode, 1'b0);
        wr(`OFS_TX_RATE_SELECT, 8'h00);
    endtask : rate_test

    task automatic pkt(input logic raw, input logic r12, input logic [1:0] vc,
        input logic [5:0] dt, input logic [7:0] di, input logic [7:0] pay[$]);
        logic [7:0] e[$];
        logic [15:0] wc;
        logic [15:0] c;
        logic t;
        int k;
        k = 0;
        wc = 16'(pay.size());
        c = crc(pay);
        e = '{di, wc[7:0], wc[15:8], ecc({wc, di})};
        if (di[5:0] > `SHORT_DT_MAX)
            e = {e, pay, c[7:0], c[15:8]};
        rx.q0.delete();
        rx.q1.delete();
        i_pkt_raw = raw;
        i_pkt_raw12 = r12;
        i_pkt_vc = vc;
        i_pkt_dt = dt;
        i_pkt_wc = wc;
        check(pkt_ready, 1'b1);
        i_pkt_valid = 1'b1;
        run = 1'b1;
        @(posedge i_clk);
        #1 i_pkt_valid = 1'b0;
        check(pkt_ready, 1'b0);
        for (int g = 0; g < 3000 && rx.q0.size() < e.size(); g++)
        begin
            i_pay_valid = k < pay.size() && g % 20 < 12;
            i_pay_data = k < pay.size() ? pay[k] : 8'h00;
            @(negedge i_clk) t = pay_ready & i_pay_valid;
            @(posedge i_clk);
            #1 k += int'(t);
        end
        i_pay_valid = 1'b0;
        if (rx.q0.size() < e.size())
        begin
            err_count++;
            stop_test();
        end
        repeat (24) @(posedge i_clk);
        #1 run = 1'b0;
        check(pkt_ready, 1'b1);
        check(16'(rx.q0.size()), 16'(e.size()));
        foreach (e[i])
            check(rx.q0[i], e[i]);
        if (lane1)
            foreach (e[i])
                check(rx.q1[i], e[i]);
        else
            check(16'(rx.q1.size()), 16'h0000);
    endtask : pkt

    initial
    begin
        err_count = 0;
        n_compared = 0;
        i_rst = 1'b1;
        run = 1'b0;
        {i_reg_wr, i_reg_rd, i_pkt_valid, i_pkt_port, i_pkt_raw, i_pkt_raw12, i_pay_valid} = '0;
        {i_reg_addr, i_reg_wdata, i_pay_data, i_pkt_dt, i_pkt_vc, i_rx_lock, i_pkt_wc} = '0;
        i_power_down_pin_n = 1'b1;
        repeat (20) @(posedge i_clk);
        #1 i_rst = 1'b0;
        @(posedge i_clk);
        #1;
        reg_test();
        pin_test();
        rate_test();
        pkt(1'b1, 1'b0, 2'h0, 6'h00, 8'h2b, '{8'h11, 8'h80, 8'hfe});
        wr(`OFS_RAW12_CONTEXT_ID, 8'hec);
        pkt(1'b1, 1'b1, 2'h0, 6'h00, 8'hec, '{8'h01});
        wr(`OFS_RX_PORT_SELECT, 8'h01);
        wr(`OFS_RAW10_CONTEXT_ID, 8'h5e);
        i_pkt_port = 1'b1;
        pkt(1'b1, 1'b0, 2'h0, 6'h00, 8'h5e, '{8'h33, 8'hc4});
        i_pkt_port = 1'b0;
        wr(`OFS_RX_PORT_SELECT, 8'h00);
        wr(`OFS_CHANNEL_REMAP, 8'h1b);
        pkt(1'b0, 1'b0, 2'h1, 6'h2a, 8'haa, '{8'h00, 8'hff, 8'h5a, 8'ha5});
        pkt(1'b0, 1'b0, 2'h3, 6'h10, 8'h10, none);
        wr(`OFS_FORWARDING_CONTROL_TWO, 8'h01);
        check(lane1, 1'b1);
        pkt(1'b0, 1'b0, 2'h0, 6'h0f, 8'hcf, none);
        stop_test();
    end
endmodule : csi2_tx_packet_output_control_test
